// ### core/mc_pkg.sv
// Shared constants, register map and decode functions of the misc configuration bank
package mc_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_DIM_REG = 10'h056;
  localparam logic [9:0] IDX_FREQ_REF = 10'h057;
  localparam logic [9:0] IDX_TMO_SUP = 10'h058;
  localparam logic [9:0] IDX_OD_DIAG = 10'h059;
  localparam logic [9:0] IDX_WDOG = 10'h05A;
  localparam logic [9:0] IDX_SHORT_TH = 10'h05B;

  // ==========================================================================
  // Writable bit masks; everything outside reads zero
  localparam logic [7:0] WMASK_DIM_REG = 8'hD0;
  localparam logic [7:0] WMASK_FREQ_REF = 8'hF3;
  localparam logic [7:0] WMASK_TMO_SUP = 8'h7F;
  localparam logic [7:0] WMASK_OD_DIAG = 8'hFF;
  localparam logic [7:0] WMASK_WDOG = 8'hF0;
  localparam logic [7:0] WMASK_SHORT_TH = 8'hFF;
  // Bits of the first register taken from the shadow image at reset
  localparam logic [7:0] NVMASK_DIM_REG = 8'h50;
  // Value every register holds while reset is asserted
  localparam logic [7:0] RST_VAL = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int AUTO_SHORT_BIT = 7;
  localparam int REG_SEL_BIT = 6;
  localparam int EXP_DIM_BIT = 4;
  localparam int DIM_FREQ_LSB = 4;
  localparam int REF_RATIO_LSB = 0;
  localparam int IDLE_TMO_LSB = 4;
  localparam int LOW_SUP_LSB = 0;
  localparam int OD_CUR_LSB = 4;
  localparam int OD_PW_LSB = 0;
  localparam int WDOG_LSB = 4;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WDOG_OFF_CODE = 4'h0;
  localparam logic [3:0] WDOG_ZERO_MIN = 4'hC;
  localparam logic [3:0] OD_CUR_CH_CODE = 4'hF;
  localparam logic [4:0] LOW_SUP_BASE_V = 5'h05;
  localparam logic [9:0] REF_RATIO_BASE = 10'h040;

  typedef enum logic {PH_LOAD, PH_RUN} mc_phase_e;

  // ==========================================================================
  // Watchdog period in microseconds; zero where no count applies
  function automatic logic [19:0] mc_wdog_us(input logic [3:0] c);
    case (c)
      4'h1: mc_wdog_us = 20'd200;
      4'h2: mc_wdog_us = 20'd500;
      4'h3: mc_wdog_us = 20'd1000;
      4'h4: mc_wdog_us = 20'd2000;
      4'h5: mc_wdog_us = 20'd5000;
      4'h6: mc_wdog_us = 20'd10000;
      4'h7: mc_wdog_us = 20'd20000;
      4'h8: mc_wdog_us = 20'd50000;
      4'h9: mc_wdog_us = 20'd100000;
      4'hA: mc_wdog_us = 20'd200000;
      4'hB: mc_wdog_us = 20'd500000;
      default: mc_wdog_us = 20'd0;
    endcase
  endfunction : mc_wdog_us

  // Link idle timeout in microseconds
  function automatic logic [19:0] mc_idle_us(input logic [2:0] c);
    case (c)
      3'h0: mc_idle_us = 20'd1000;
      3'h1: mc_idle_us = 20'd125;
      3'h2: mc_idle_us = 20'd250;
      3'h3: mc_idle_us = 20'd500;
      3'h4: mc_idle_us = 20'd1250;
      3'h5: mc_idle_us = 20'd2500;
      3'h6: mc_idle_us = 20'd5000;
      default: mc_idle_us = 20'd10000;
    endcase
  endfunction : mc_idle_us

endpackage : mc_pkg

// ### core/mc_tmr_if.sv
// Control and status bundle between the bank and one inactivity timer
`timescale 1ns/1ps
interface mc_tmr_if;
  logic [19:0] period_us;
  logic off;
  logic zero;
  logic kick;
  logic expired;
  modport ctl (output period_us, output off, output zero, output kick, input expired);
  modport tmr (input period_us, input off, input zero, input kick, output expired);
endinterface : mc_tmr_if

// ### core/mc_tick.sv
// Microsecond tick prescaler shared by the inactivity timers
`timescale 1ns/1ps
module mc_tick #(
  parameter int CYC_US = 100
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  output logic tick
);
  logic [15:0] cnt_r;

  // Free-running divider; one pulse per microsecond
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= (cnt_r == 16'(CYC_US - 1));
      cnt_r <= (cnt_r == 16'(CYC_US - 1)) ? 16'h0000 : cnt_r + 16'h0001;
    end
  end
endmodule : mc_tick

// ### core/mc_timer.sv
// Inactivity timer: expires after a programmed number of microseconds
`timescale 1ns/1ps
module mc_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  mc_tmr_if.tmr t
);
  logic [19:0] cnt_r;

  // Kick restarts the count; expiry holds until off, or a kick while zero is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 20'h00000;
      t.expired <= 1'b0;
    end else if (ce) begin
      if (t.off) begin
        cnt_r <= 20'h00000;
        t.expired <= 1'b0;
      end else if (t.kick) begin
        cnt_r <= 20'h00000;
        t.expired <= t.zero;
      end else if (t.zero) begin
        t.expired <= 1'b1;
      end else if (tick && !t.expired) begin
        cnt_r <= cnt_r + 20'h00001;
        if (cnt_r + 20'h00001 >= t.period_us) begin
          t.expired <= 1'b1;
        end
      end
    end
  end
endmodule : mc_timer

// ### core/mc_misc_cfg.sv
// Misc configuration register bank of the LED driver, reached over APB
//
// Summary of operation
// - Bit 7 of the first register enables automatic single-LED short checking, reset to 0.
// - Regulator select zero picks the higher output voltage and one the lower.
// - Bit 4 of the first register switches dimming to the exponential curve when set.
// - Every field without a fixed reset value loads from its shadow image on reset.
// - Bits 7-4 of the second register pick one of sixteen ascending dimming frequencies.
// - Bits 1-0 of the second register pick a reference ratio of 64, 128, 256 or 512.
// - Bits 6-4 of the third register pick the link idle timeout from 125 us to 10 ms.
// - Bits 3-0 of the third register set the low-supply trip level from 5 V to 20 V.
// - Diagnostic current codes 0-14 give (4 code + 1)/64 of full range, 15 the channel's own.
// - Bits 3-0 of the fourth register set the diagnostic pulse width, code 0 is 100 us.
// - Bits 7-4 of the fifth register set the watchdog period, codes 1-11 from 200 us to 500 ms.
// - Watchdog code 0 disables the watchdog so link silence never forces fail-safe.
// - Watchdog codes 12-15 mean zero timeout and fail-safe is entered directly.
// - The first register sits at index 0x56 and its shadow-backed bits load at reset.
`timescale 1ns/1ps
module mc_misc_cfg
  import mc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CYC_US = CYC_PER_US
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Shadow images, one per register
  input wire logic [7:0] NVM_DIM_REG,
  input wire logic [7:0] NVM_FREQ_REF,
  input wire logic [7:0] NVM_TMO_SUP,
  input wire logic [7:0] NVM_OD_DIAG,
  input wire logic [7:0] NVM_WDOG,
  input wire logic [7:0] NVM_SHORT_TH,
  // Link activity pulse, same clock domain
  input wire logic LINK_ACTIVITY,
  // Settings to the datapaths
  output logic CFG_VALID,
  output logic AUTO_SINGLE_SHORT_EN,
  output logic REGULATOR_LOW_SEL,
  output logic EXP_DIMMING_EN,
  output logic [3:0] DIM_FREQ_SEL,
  output logic [9:0] REF_RATIO,
  output logic [4:0] LOW_SUPPLY_VOLTS,
  output logic [5:0] ONDEMAND_CURRENT_NUM,
  output logic ONDEMAND_USE_CH_CURRENT,
  output logic [3:0] ONDEMAND_PULSE_WIDTH,
  output logic [7:0] SHORT_THRESHOLD,
  output logic LINK_IDLE,
  output logic FAILSAFE_REQ
);

  // ==========================================================================
  // Declarations
  // Registers hold only their writable bits; reserved bits are never stored
  mc_phase_e phase_r;
  logic [7:0] dim_reg_r;
  logic [7:0] freq_ref_r;
  logic [7:0] tmo_sup_r;
  logic [7:0] od_diag_r;
  logic [7:0] wdog_r;
  logic [7:0] short_th_r;
  logic [9:0] idx;
  logic hit;
  logic err;
  logic access;
  logic wr_commit;
  logic [7:0] wdat;
  logic [7:0] rd_nxt;
  logic tick;
  logic [3:0] wd_code;
  logic [2:0] idle_code;
  logic [3:0] od_cur;
  logic [3:0] low_sup;
  logic load;

  // One bundle per timer; the bank drives the controls, the timer the flag
  mc_tmr_if wd_if ();
  mc_tmr_if idle_if ();

  // ==========================================================================
  // Bus decode
  // One index decode feeds the write strobes, the read mux and the error
  // answer, so the three can never disagree about which register is named
  // Low two address bits must be zero; anything else is answered with an error
  assign idx = 10'(PADDR >> 2);
  assign hit = (idx >= IDX_DIM_REG) && (idx <= IDX_SHORT_TH) && (PADDR[1:0] == 2'b00);
  assign err = !hit;
  assign access = PSEL && PENABLE;
  // Write takes effect only at the edge where the master sees PREADY high
  assign wr_commit = access && PREADY && PWRITE && hit && CLK_EN;
  assign wdat = PWDATA[7:0];
  assign load = (phase_r == PH_LOAD) && CLK_EN;

  // ==========================================================================
  // Reset sequencing
  // Async reset can only force constants, so shadow images load one edge after release
  // While the phase still says load, the bus answer and both timers are held
  // off, so nothing outside ever sees a half-loaded bank
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_r <= PH_LOAD;
    end else if (CLK_EN) begin
      phase_r <= PH_RUN;
    end
  end

  // ==========================================================================
  // Registers
  // Each register takes its shadow image once, then belongs to software
  // Masks sit on both paths, so stray reserved bits in an image still read zero
  // A write cannot meet the load, as the bus answer is held off until it is done
  // First register: short check has a fixed reset, the rest comes from shadow
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dim_reg_r <= RST_VAL;
    end else if (load) begin
      dim_reg_r <= NVM_DIM_REG & NVMASK_DIM_REG;
    end else if (wr_commit && idx == IDX_DIM_REG) begin
      dim_reg_r <= wdat & WMASK_DIM_REG;
    end
  end

  // Dimming frequency and reference ratio
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      freq_ref_r <= RST_VAL;
    end else if (load) begin
      freq_ref_r <= NVM_FREQ_REF & WMASK_FREQ_REF;
    end else if (wr_commit && idx == IDX_FREQ_REF) begin
      freq_ref_r <= wdat & WMASK_FREQ_REF;
    end
  end

  // Link timeout and low-supply threshold
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tmo_sup_r <= RST_VAL;
    end else if (load) begin
      tmo_sup_r <= NVM_TMO_SUP & WMASK_TMO_SUP;
    end else if (wr_commit && idx == IDX_TMO_SUP) begin
      tmo_sup_r <= wdat & WMASK_TMO_SUP;
    end
  end

  // On-demand diagnostic current and pulse width
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      od_diag_r <= RST_VAL;
    end else if (load) begin
      od_diag_r <= NVM_OD_DIAG & WMASK_OD_DIAG;
    end else if (wr_commit && idx == IDX_OD_DIAG) begin
      od_diag_r <= wdat & WMASK_OD_DIAG;
    end
  end

  // Watchdog period
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wdog_r <= RST_VAL;
    end else if (load) begin
      wdog_r <= NVM_WDOG & WMASK_WDOG;
    end else if (wr_commit && idx == IDX_WDOG) begin
      wdog_r <= wdat & WMASK_WDOG;
    end
  end

  // Short threshold; its field layout is owned by the converter logic
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      short_th_r <= RST_VAL;
    end else if (load) begin
      short_th_r <= NVM_SHORT_TH & WMASK_SHORT_TH;
    end else if (wr_commit && idx == IDX_SHORT_TH) begin
      short_th_r <= wdat & WMASK_SHORT_TH;
    end
  end

  // ==========================================================================
  // Read mux
  // Unmapped indices fall through to zero; the answer process flags them
  always_comb begin
    rd_nxt = 8'h00;
    case (idx)
      IDX_DIM_REG: rd_nxt = dim_reg_r;
      IDX_FREQ_REF: rd_nxt = freq_ref_r;
      IDX_TMO_SUP: rd_nxt = tmo_sup_r;
      IDX_OD_DIAG: rd_nxt = od_diag_r;
      IDX_WDOG: rd_nxt = wdog_r;
      IDX_SHORT_TH: rd_nxt = short_th_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // ==========================================================================
  // APB answer
  // One wait state keeps PREADY a flop; held off until the shadow load is done
  // The answer is built from the request seen at the access edge, so the
  // master must hold address and direction until it sees PREADY
  // Ready clears itself on the next edge where CLK_EN is high, in every case
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      if (access && !PREADY && phase_r == PH_RUN) begin
        PREADY <= 1'b1;
        PSLVERR <= err;
        PRDATA <= (!PWRITE && hit) ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
      end else begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Decoded settings
  assign od_cur = od_diag_r[OD_CUR_LSB +: 4];
  assign low_sup = tmo_sup_r[LOW_SUP_LSB +: 4];

  // The extra flop costs one cycle between a write and its effect, but the
  // datapaths never see a setting glitch in the middle of a cycle
  // Registered so every setting leaves the block from a flop
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CFG_VALID <= 1'b0;
      AUTO_SINGLE_SHORT_EN <= 1'b0;
      REGULATOR_LOW_SEL <= 1'b0;
      EXP_DIMMING_EN <= 1'b0;
      DIM_FREQ_SEL <= 4'h0;
    end else if (CLK_EN) begin
      CFG_VALID <= (phase_r == PH_RUN);
      AUTO_SINGLE_SHORT_EN <= dim_reg_r[AUTO_SHORT_BIT];
      REGULATOR_LOW_SEL <= dim_reg_r[REG_SEL_BIT];
      EXP_DIMMING_EN <= dim_reg_r[EXP_DIM_BIT];
      DIM_FREQ_SEL <= freq_ref_r[DIM_FREQ_LSB +: 4];
    end
  end

  // Arithmetic decodes: ratio, trip volts, diagnostic current
  // The ratio is the base shifted by its code, so each step doubles it
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REF_RATIO <= 10'h000;
      LOW_SUPPLY_VOLTS <= 5'h00;
      ONDEMAND_CURRENT_NUM <= 6'h00;
      ONDEMAND_USE_CH_CURRENT <= 1'b0;
    end else if (CLK_EN) begin
      REF_RATIO <= REF_RATIO_BASE << freq_ref_r[REF_RATIO_LSB +: 2];
      LOW_SUPPLY_VOLTS <= LOW_SUP_BASE_V + {1'b0, low_sup};
      ONDEMAND_CURRENT_NUM <= (od_cur == OD_CUR_CH_CODE) ? 6'h00 : {od_cur, 2'b01};
      ONDEMAND_USE_CH_CURRENT <= (od_cur == OD_CUR_CH_CODE);
    end
  end

  // Pass-through codes for the diagnostic pulse and short threshold
  // The pulse code goes out raw; the pulse timer owns its table of widths
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ONDEMAND_PULSE_WIDTH <= 4'h0;
      SHORT_THRESHOLD <= 8'h00;
    end else if (CLK_EN) begin
      ONDEMAND_PULSE_WIDTH <= od_diag_r[OD_PW_LSB +: 4];
      SHORT_THRESHOLD <= short_th_r;
    end
  end

  // ==========================================================================
  // Link timers
  // Both timers share one microsecond prescaler whose phase a kick does not
  // reset, so an expiry may come up to one microsecond early; that slack is
  // far below the shortest period and saves a divider per timer
  assign wd_code = wdog_r[WDOG_LSB +: 4];
  assign idle_code = tmo_sup_r[IDLE_TMO_LSB +: 3];

  // Codes 12 to 15 hold the expiry high through any link activity, since the
  // restart inside the timer reloads the expiry from the zero flag
  // Watchdog; rewriting the period restarts the count
  assign wd_if.period_us = mc_wdog_us(wd_code);
  assign wd_if.off = (wd_code == WDOG_OFF_CODE) || (phase_r == PH_LOAD);
  assign wd_if.zero = (wd_code >= WDOG_ZERO_MIN);
  assign wd_if.kick = LINK_ACTIVITY || (wr_commit && idx == IDX_WDOG);

  // Idle timeout is never disabled once loaded
  // Its code 0 is a real 1 ms period, unlike the watchdog's off code
  assign idle_if.period_us = mc_idle_us(idle_code);
  assign idle_if.off = (phase_r == PH_LOAD);
  assign idle_if.zero = 1'b0;
  assign idle_if.kick = LINK_ACTIVITY || (wr_commit && idx == IDX_TMO_SUP);

  // Shared prescaler; CYC_US sets the MCLK cycles in one microsecond
  mc_tick #(
    .CYC_US(CYC_US)
  ) u_tick (
    .clk(MCLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .tick(tick)
  );

  // Watchdog timer
  mc_timer u_wdog (
    .clk(MCLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .tick(tick),
    .t(wd_if)
  );

  // Link idle timer
  mc_timer u_idle (
    .clk(MCLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .tick(tick),
    .t(idle_if)
  );

  // Timer flags pass through one flop on the way out
  // Both flags are levels; the fail-safe logic decides what to latch
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FAILSAFE_REQ <= 1'b0;
      LINK_IDLE <= 1'b0;
    end else if (CLK_EN) begin
      FAILSAFE_REQ <= wd_if.expired;
      LINK_IDLE <= idle_if.expired;
    end
  end

endmodule : mc_misc_cfg

// ### sim/mc_misc_cfg_asserts.sv
// Concurrent checks on the ports of the misc configuration bank
`timescale 1ns/1ps
module mc_misc_cfg_asserts
  import mc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CFG_VALID,
  input wire logic AUTO_SINGLE_SHORT_EN,
  input wire logic REGULATOR_LOW_SEL,
  input wire logic EXP_DIMMING_EN,
  input wire logic [3:0] DIM_FREQ_SEL,
  input wire logic [9:0] REF_RATIO,
  input wire logic [4:0] LOW_SUPPLY_VOLTS,
  input wire logic [5:0] ONDEMAND_CURRENT_NUM,
  input wire logic ONDEMAND_USE_CH_CURRENT,
  input wire logic [3:0] ONDEMAND_PULSE_WIDTH,
  input wire logic FAILSAFE_REQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // ==========================================================================
  // Address decode seen from outside; a read also shows what the outputs must decode
  logic [ADDR_W-3:0] idx;
  logic ok;
  logic [3:0] c;
  assign idx = PADDR[ADDR_W-1:2];
  assign ok = (PADDR[1:0] == 2'h0) && (idx >= IDX_DIM_REG) && (idx <= IDX_SHORT_TH);
  assign c = PRDATA[7:4];
  sequence access_s;
    PSEL && PENABLE && !PREADY && CFG_VALID;
  endsequence
  sequence rd_s(logic [9:0] i);
    PREADY && !PWRITE && ok && (idx == i);
  endsequence
  // ==========================================================================
  // Bus handshake and refusals
  ready_wait_a: assert property (access_s |=> PREADY) else $error("no answer");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("stray ready");
  bad_addr_a: assert property (PREADY && !ok |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (PREADY && ok |-> !PSLVERR && PRDATA[31:8] == 24'h0)
    else $error("mapped access refused");
  // ==========================================================================
  // Decoded settings agree with the register that software reads back
  misc0_map_a: assert property (rd_s(IDX_DIM_REG) |-> AUTO_SINGLE_SHORT_EN == PRDATA[7]
    && REGULATOR_LOW_SEL == PRDATA[6] && EXP_DIMMING_EN == PRDATA[4] && PRDATA[5] == 1'b0
    && PRDATA[3:0] == 4'h0)
    else $error("first register decode wrong");
  freq_ref_a: assert property (rd_s(IDX_FREQ_REF) |-> DIM_FREQ_SEL == c
    && REF_RATIO == (REF_RATIO_BASE << PRDATA[1:0]) && PRDATA[3:2] == 2'h0)
    else $error("frequency or ratio decode wrong");
  supply_map_a: assert property (rd_s(IDX_TMO_SUP) |-> PRDATA[7] == 1'b0
    && LOW_SUPPLY_VOLTS == LOW_SUP_BASE_V + 5'(PRDATA[3:0])) else $error("supply decode wrong");
  od_map_a: assert property (rd_s(IDX_OD_DIAG) |-> ONDEMAND_USE_CH_CURRENT == (c == 4'hF)
    && ONDEMAND_CURRENT_NUM == ((c == 4'hF) ? 6'h00 : 6'(4 * c + 1))
    && ONDEMAND_PULSE_WIDTH == PRDATA[3:0]) else $error("diagnostic decode wrong");
  wdog_zero_a: assert property (rd_s(IDX_WDOG) ##0 c >= WDOG_ZERO_MIN |-> FAILSAFE_REQ)
    else $error("zero timeout without fail-safe");
endmodule : mc_misc_cfg_asserts

bind mc_misc_cfg mc_misc_cfg_asserts #(.ADDR_W(ADDR_W)) mc_misc_cfg_asserts_i (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CFG_VALID(CFG_VALID),
  .AUTO_SINGLE_SHORT_EN(AUTO_SINGLE_SHORT_EN), .REGULATOR_LOW_SEL(REGULATOR_LOW_SEL),
  .EXP_DIMMING_EN(EXP_DIMMING_EN), .DIM_FREQ_SEL(DIM_FREQ_SEL), .REF_RATIO(REF_RATIO),
  .LOW_SUPPLY_VOLTS(LOW_SUPPLY_VOLTS), .ONDEMAND_CURRENT_NUM(ONDEMAND_CURRENT_NUM),
  .ONDEMAND_USE_CH_CURRENT(ONDEMAND_USE_CH_CURRENT),
  .ONDEMAND_PULSE_WIDTH(ONDEMAND_PULSE_WIDTH), .FAILSAFE_REQ(FAILSAFE_REQ));

// ### sim/mc_misc_cfg_bench.sv
// Self-checking bench of the misc configuration bank
`timescale 1ns/1ps
module mc_misc_cfg_bench
  import mc_pkg::*;
;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic LINK_ACTIVITY = 1'b0;
  logic CLK_EN = 1'b1;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, CFG_VALID, AUTO_SS, REG_LOW, EXP_EN, USE_CH, LINK_IDLE, FAILSAFE_REQ;
  logic [3:0] DIM_FREQ_SEL, OD_PW;
  logic [9:0] REF_RATIO;
  logic [4:0] LOW_SUP;
  logic [5:0] OD_NUM;
  logic [7:0] SHORT_TH;
  logic [7:0] nvm [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] model [6];
  logic [7:0] wm [6] = '{WMASK_DIM_REG, WMASK_FREQ_REF, WMASK_TMO_SUP, WMASK_OD_DIAG,
    WMASK_WDOG, WMASK_SHORT_TH};
  logic [31:0] lf = 32'hACAB;
  int miscompares = 0;
  int compares = 0;

  // Timers shortened to one cycle per microsecond so expiries fit the run
  mc_misc_cfg #(.CYC_US(1)) mc_misc_cfg_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .NVM_DIM_REG(nvm[0]),
    .NVM_FREQ_REF(nvm[1]), .NVM_TMO_SUP(nvm[2]), .NVM_OD_DIAG(nvm[3]), .NVM_WDOG(nvm[4]),
    .NVM_SHORT_TH(nvm[5]), .LINK_ACTIVITY(LINK_ACTIVITY), .CFG_VALID(CFG_VALID),
    .AUTO_SINGLE_SHORT_EN(AUTO_SS), .REGULATOR_LOW_SEL(REG_LOW), .EXP_DIMMING_EN(EXP_EN),
    .DIM_FREQ_SEL(DIM_FREQ_SEL), .REF_RATIO(REF_RATIO), .LOW_SUPPLY_VOLTS(LOW_SUP),
    .ONDEMAND_CURRENT_NUM(OD_NUM), .ONDEMAND_USE_CH_CURRENT(USE_CH),
    .ONDEMAND_PULSE_WIDTH(OD_PW), .SHORT_THRESHOLD(SHORT_TH), .LINK_IDLE(LINK_IDLE),
    .FAILSAFE_REQ(FAILSAFE_REQ));

  // ==========================================================================
  // Clock and helpers
  always #5 MCLK = ~MCLK;

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd

  function automatic logic [11:0] ad(input int k);
    return {IDX_DIM_REG + 10'(k), 2'b00};
  endfunction : ad

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // One APB transfer; starts after a rising edge, answer taken at the edge that sees PREADY
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'(rnd()), d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = PRDATA[7:0];
    e = PSLVERR;
    check(PRDATA[31:8], 32'h0);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input int k, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, ad(k), d, q, e);
    check(e, 0);
    model[k] = d & wm[k];
  endtask : wr

  task automatic rd_all();
    logic [7:0] q;
    logic e;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ad(i), 8'h00, q, e);
      check({e, q}, {1'b0, model[i]});
    end
  endtask : rd_all

  // Reset with fresh shadow images; only shadow-backed bits may come through
  task automatic do_reset();
    SYS_RST <= 1'b1;
    for (int i = 0; i < 6; i++) nvm[i] <= 8'(rnd());
    repeat (5) @(posedge MCLK);
    check({PREADY, CFG_VALID, FAILSAFE_REQ}, 0);
    SYS_RST <= 1'b0;
    repeat (3) @(posedge MCLK);
    for (int i = 0; i < 6; i++) model[i] = nvm[i] & ((i == 0) ? NVMASK_DIM_REG : wm[i]);
    check(CFG_VALID, 1);
  endtask : do_reset

  task automatic pulse_act();
    @(posedge MCLK);
    LINK_ACTIVITY <= 1'b1;
    @(posedge MCLK);
    LINK_ACTIVITY <= 1'b0;
    repeat (3) @(negedge MCLK);
  endtask : pulse_act

  task automatic chk_dec();
    repeat (3) @(negedge MCLK);
    check({AUTO_SS, REG_LOW, EXP_EN}, {model[0][7:6], model[0][4]});
    check({DIM_FREQ_SEL, REF_RATIO}, {model[1][7:4], 10'h040 << model[1][1:0]});
    check(LOW_SUP, 5 + model[2][3:0]);
    check({OD_PW, SHORT_TH}, {model[3][3:0], model[5]});
    check(OD_NUM, (model[3][7:4] == 4'hF) ? 0 : 4 * model[3][7:4] + 1);
  endtask : chk_dec

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] q;
    logic e;
    do_reset();
    rd_all();
    wr(0, 8'hFF);
    wr(3, 8'hF5);
    chk_dec();
    check(USE_CH, 1);
    repeat (40) begin
      wr(int'(rnd() % 6), 8'(rnd()));
    end
    rd_all();
    chk_dec();
    apb(1'b1, 12'h170, 8'hFF, q, e);
    check(e, 1);
    apb(1'b0, 12'h159, 8'h00, q, e);
    check({e, q}, 9'h100);
    apb(1'b0, 12'h154, 8'h00, q, e);
    check({e, q}, 9'h100);
    rd_all();
    // Watchdog: a real period, then off, then the zero-timeout codes
    wr(4, 8'h10);
    // Clock enable low for 30 edges must push the expiry back by as much
    CLK_EN <= 1'b0;
    repeat (30) @(posedge MCLK);
    CLK_EN <= 1'b1;
    repeat (190) @(negedge MCLK);
    check(FAILSAFE_REQ, 0);
    repeat (20) @(negedge MCLK);
    check(FAILSAFE_REQ, 1);
    pulse_act();
    check(FAILSAFE_REQ, 0);
    wr(4, 8'h00);
    repeat (600) @(negedge MCLK);
    check(FAILSAFE_REQ, 0);
    for (int c = 12; c < 16; c++) begin
      wr(4, 8'(c << 4));
      rd_all();
      pulse_act();
      check(FAILSAFE_REQ, 1);
    end
    // Idle timeout: shortest code, then code zero which is 1 ms
    wr(2, 8'h13);
    repeat (115) @(negedge MCLK);
    check(LINK_IDLE, 0);
    repeat (20) @(negedge MCLK);
    check(LINK_IDLE, 1);
    wr(2, 8'h03);
    repeat (985) @(negedge MCLK);
    check(LINK_IDLE, 0);
    repeat (25) @(negedge MCLK);
    check(LINK_IDLE, 1);
    // A second reset in mid-run reloads from new images
    do_reset();
    rd_all();
    chk_dec();
    final_report();
  end

  // Watchdog of the bench against a hang
  initial begin
    repeat (20000) @(posedge MCLK);
    miscompares++;
    final_report();
  end
endmodule : mc_misc_cfg_bench
